// ---- hw/tct_timer.sv ----
// three channel 16-bit interval timer with avalon-mm register access
// assumes mclk_i at 100 mhz; gate, event and jumper pins are asynchronous to it
// Functional notes
// (RULE1) three independent timers, 16-bit counting register each
// (RULE2) timer 0 output drives serial baud clock
// (RULE3) timers 1 and 2 time intervals, count events
// (RULE4) no timer output clocks another timer
// (RULE5) seven modes selectable per timer
// (RULE6) binary or bcd counting per timer
// (RULE7) live count readable anytime without stopping
// (RULE8) terminal count mode raises interrupt at zero
// (RULE9) one-shot low on trigger, high at zero, retriggerable
// (RULE10) rate mode: one-period low pulse every N
// (RULE11) square wave: high first half, low second
// (RULE12) software strobe: low one period N after load
// (RULE13) hardware strobe: low one period N after trigger
// (RULE14) event mode counts jumper-selected external events
// (RULE15) timers 1 and 2 outputs are interrupt sources
// (RULE16) baud timer supports rates up to 19.2 kbaud
// (RULE17) timers count from a 1.23 mhz time base
// (RULE18) decrement per tick, wrap 65536 or 10000
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "tct_cfg.svh"

module tct_timer (
	input  wire logic                    mclk_i,
	input  wire logic                    rst_n_i,
	input  wire logic [`TCT_ADDR_W-1:0]  avs_address_i,
	input  wire logic                    avs_read_i,
	input  wire logic                    avs_write_i,
	input  wire logic [31:0]             avs_writedata_i,
	input  wire logic [3:0]              avs_byteenable_i,
	output logic      [31:0]             avs_readdata_o,
	output logic                         avs_waitrequest_o,
	input  wire logic [`TCT_NCH-1:0]     gate_i,
	input  wire logic [`TCT_NGP-1:0]     ext_evt_i,
	input  wire logic [`TCT_NGP-1:0]     evt_jmp_i,
	output logic                         baud_clk_o,
	output logic      [`TCT_NGP-1:0]     gp_out_o,
	output logic                         irq_o
);

////////////////////////////////////////////////////////////////////////////////
// helpers
	function automatic logic [`TCT_CW-1:0] dec_cnt(input logic [`TCT_CW-1:0] v, input logic bcd);
		logic [`TCT_CW-1:0] r;
		logic               brw;
		r   = v;
		brw = 1'b1;
		if (!bcd) begin
			r = v - 16'h0001;
		end else begin
			for (int d = 0; d < 4; d++) begin
				if (brw) begin
					if (v[d*4 +: 4] == 4'h0) begin
						r[d*4 +: 4] = 4'h9;
					end else begin
						r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
						brw         = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction : dec_cnt

	function automatic logic [`TCT_CW-1:0] half_cnt(input logic [`TCT_CW-1:0] v, input logic bcd);
		logic [`TCT_CW-1:0] r;
		logic [4:0]         dg;
		logic               rem;
		r   = v >> 1;
		rem = 1'b0;
		if (bcd) begin
			for (int d = 3; d >= 0; d--) begin
				dg          = {1'b0, v[d*4 +: 4]} + (rem ? 5'h0a : 5'h00);
				r[d*4 +: 4] = dg[4:1];
				rem         = dg[0];
			end
		end
		return r;
	endfunction : half_cnt

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

////////////////////////////////////////////////////////////////////////////////
// declarations
	tct_pkg::tct_ctrl_t              ctrl     [`TCT_NCH];
	logic [`TCT_CW-1:0]              reload   [`TCT_NCH];
	logic [`TCT_CW-1:0]              cnt      [`TCT_NCH];
	logic [`TCT_NCH-1:0]             run;
	logic [`TCT_NCH-1:0]             tout;
	logic [`TCT_NGP-1:0]             gp_prev;
	logic [`TCT_NGP-1:0]             irq_stat;
	logic [`TCT_NGP-1:0]             irq_mask;
	logic [`TCT_ACC_W-1:0]           acc;
	logic                            tick;
	logic [`TCT_NCH-1:0]             gate_s1;
	logic [`TCT_NCH-1:0]             gate_s2;
	logic [`TCT_NCH-1:0]             gate_s3;
	logic [`TCT_NGP-1:0]             evt_s1;
	logic [`TCT_NGP-1:0]             evt_s2;
	logic [`TCT_NGP-1:0]             evt_s3;
	logic [`TCT_NGP-1:0]             jmp_s1;
	logic [`TCT_NGP-1:0]             jmp_s2;
	logic                            acc_go;
	logic                            do_wr;
	logic                            do_rd;
	logic [31:0]                     wmerge;
	logic [`TCT_NCH-1:0]             ctl_wr;
	logic [`TCT_NCH-1:0]             ld_wr;
	logic [`TCT_NCH-1:0]             sw_trig;
	logic [`TCT_NCH-1:0]             hw_trig;
	logic [`TCT_NCH-1:0]             step;
	logic [`TCT_NCH-1:0]             evt_rise;
	logic [`TCT_NCH-1:0]             evt_sel;
	logic [`TCT_NGP-1:0]             stat_set;
	logic                            stat_rd;
	logic [31:0]                     next_rdata;

////////////////////////////////////////////////////////////////////////////////
// time base: fractional divider, 100 mhz down to 1.23 mhz
	// exact long-term rate; single ticks jitter by one mclk period
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc  <= '0;
			tick <= 1'b0;
		end else if ({1'b0, acc} + 18'(`TCT_IN_KHZ) >= 18'(`TCT_SYS_KHZ)) begin
			acc  <= `TCT_ACC_W'(acc + `TCT_ACC_W'(`TCT_IN_KHZ) - `TCT_ACC_W'(`TCT_SYS_KHZ)); // RULE17
			tick <= 1'b1;
		end else begin
			acc  <= `TCT_ACC_W'(acc + `TCT_ACC_W'(`TCT_IN_KHZ));
			tick <= 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{gate_s3, gate_s2, gate_s1} <= '0;
			{evt_s3, evt_s2, evt_s1}    <= '0;
			{jmp_s2, jmp_s1}            <= '0;
		end else begin
			{gate_s3, gate_s2, gate_s1} <= {gate_s2, gate_s1, gate_i};
			{evt_s3, evt_s2, evt_s1}    <= {evt_s2, evt_s1, ext_evt_i};
			{jmp_s2, jmp_s1}            <= {jmp_s1, evt_jmp_i};
		end
	end

////////////////////////////////////////////////////////////////////////////////
// bus decode
	assign acc_go  = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
	assign do_wr   = acc_go & avs_write_i;
	assign do_rd   = acc_go & avs_read_i;
	assign wmerge  = be_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
	assign stat_rd = do_rd && (avs_address_i == `TCT_OFF_STATUS);

	always_comb begin
		ctl_wr  = '0;
		ld_wr   = '0;
		sw_trig = '0;
		if (do_wr) begin
			if (avs_address_i == `TCT_OFF_CTRL0) begin
				ctl_wr[0] = 1'b1;
			end else if (avs_address_i == `TCT_OFF_CTRL1) begin
				ctl_wr[1] = 1'b1;
			end else if (avs_address_i == `TCT_OFF_CTRL2) begin
				ctl_wr[2] = 1'b1;
			end else if (avs_address_i == `TCT_OFF_RELOAD0) begin
				ld_wr[0] = 1'b1;
			end else if (avs_address_i == `TCT_OFF_RELOAD1) begin
				ld_wr[1] = 1'b1;
			end else if (avs_address_i == `TCT_OFF_RELOAD2) begin
				ld_wr[2] = 1'b1;
			end else if (avs_address_i == `TCT_OFF_CMD) begin
				sw_trig = wmerge[`TCT_NCH-1:0];
			end
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (avs_address_i == `TCT_OFF_CTRL0) begin
			next_rdata[`TCT_CTRL_W-1:0] = ctrl[0];
		end else if (avs_address_i == `TCT_OFF_CTRL1) begin
			next_rdata[`TCT_CTRL_W-1:0] = ctrl[1];
		end else if (avs_address_i == `TCT_OFF_CTRL2) begin
			next_rdata[`TCT_CTRL_W-1:0] = ctrl[2];
		end else if (avs_address_i == `TCT_OFF_RELOAD0) begin
			next_rdata[`TCT_CW-1:0] = reload[0];
		end else if (avs_address_i == `TCT_OFF_RELOAD1) begin
			next_rdata[`TCT_CW-1:0] = reload[1];
		end else if (avs_address_i == `TCT_OFF_RELOAD2) begin
			next_rdata[`TCT_CW-1:0] = reload[2];
		end else if (avs_address_i == `TCT_OFF_COUNT0) begin
			next_rdata[`TCT_CW-1:0] = cnt[0]; // RULE7
		end else if (avs_address_i == `TCT_OFF_COUNT1) begin
			next_rdata[`TCT_CW-1:0] = cnt[1]; // RULE7
		end else if (avs_address_i == `TCT_OFF_COUNT2) begin
			next_rdata[`TCT_CW-1:0] = cnt[2]; // RULE7
		end else if (avs_address_i == `TCT_OFF_STATUS) begin
			// an edge in the sampling cycle is reported, since the clear follows
			next_rdata[`TCT_NGP-1:0] = irq_stat | stat_set;
		end else if (avs_address_i == `TCT_OFF_MASK) begin
			next_rdata[`TCT_NGP-1:0] = irq_mask;
		end else if (avs_address_i == `TCT_OFF_OUTS) begin
			next_rdata[`TCT_NCH-1:0] = tout;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// bus handshake: one wait cycle, answer on the second edge
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
		end else begin
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
			if (avs_read_i & avs_waitrequest_o) begin
				avs_readdata_o <= next_rdata;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// software registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int c = 0; c < `TCT_NCH; c++) begin
				ctrl[c]   <= `TCT_CTRL_RST;
				reload[c] <= `TCT_RELOAD_RST;
			end
			irq_mask <= `TCT_IRQ_RST;
		end else begin
			for (int c = 0; c < `TCT_NCH; c++) begin
				if (ctl_wr[c]) begin
					ctrl[c] <= wmerge[`TCT_CTRL_W-1:0]; // RULE5 RULE6
				end
				if (ld_wr[c]) begin
					reload[c] <= wmerge[`TCT_CW-1:0];
				end
			end
			if (do_wr && avs_address_i == `TCT_OFF_MASK) begin
				irq_mask <= wmerge[`TCT_NGP-1:0];
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// counting clocks and triggers
	// only pins and the time base feed the counting clock, never a timer output
	assign evt_rise = {evt_s2 & ~evt_s3, 1'b0}; // RULE4
	assign evt_sel  = {jmp_s2, 1'b0}; // RULE14
	assign hw_trig  = gate_s2 & ~gate_s3;

	always_comb begin
		for (int c = 0; c < `TCT_NCH; c++) begin
			if (ctrl[c].mode == tct_pkg::TCT_MODE_EVENT && evt_sel[c]) begin
				step[c] = ctrl[c].en & evt_rise[c]; // RULE14
			end else begin
				step[c] = ctrl[c].en & tick; // RULE18
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// counter channels
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int c = 0; c < `TCT_NCH; c++) begin
				cnt[c] <= `TCT_COUNT_RST;
			end
			run  <= '0;
			tout <= '1;
		end else begin
			for (int c = 0; c < `TCT_NCH; c++) begin // RULE1
				if (ctl_wr[c]) begin
					run[c]  <= 1'b0;
					tout[c] <= (wmerge[2:0] != tct_pkg::TCT_MODE_TC);
				end else if (ld_wr[c]) begin
					cnt[c] <= wmerge[`TCT_CW-1:0];
					run[c] <= (ctrl[c].mode != tct_pkg::TCT_MODE_ONESHT) &&
						(ctrl[c].mode != tct_pkg::TCT_MODE_HWSTB); // RULE12
					tout[c] <= (ctrl[c].mode != tct_pkg::TCT_MODE_TC) &&
						(ctrl[c].mode != tct_pkg::TCT_MODE_EVENT);
				end else if ((hw_trig[c] || sw_trig[c]) && ctrl[c].mode == tct_pkg::TCT_MODE_ONESHT) begin
					cnt[c]  <= reload[c]; // RULE9
					run[c]  <= 1'b1;
					tout[c] <= 1'b0;
				end else if (hw_trig[c] && ctrl[c].mode == tct_pkg::TCT_MODE_HWSTB) begin
					cnt[c]  <= reload[c]; // RULE13
					run[c]  <= 1'b1;
					tout[c] <= 1'b1;
				end else if (run[c] && step[c]) begin
					case (ctrl[c].mode)
						tct_pkg::TCT_MODE_TC, tct_pkg::TCT_MODE_EVENT, tct_pkg::TCT_MODE_ONESHT: begin
							cnt[c] <= dec_cnt(cnt[c], ctrl[c].bcd); // RULE18
							if (cnt[c] == 16'h0001) begin
								tout[c] <= 1'b1; // RULE8 RULE9 RULE14
							end
						end
						tct_pkg::TCT_MODE_RATE: begin
							if (cnt[c] == 16'h0001) begin
								cnt[c]  <= reload[c];
								tout[c] <= 1'b1;
							end else begin
								cnt[c]  <= dec_cnt(cnt[c], ctrl[c].bcd);
								tout[c] <= (cnt[c] != 16'h0002); // RULE10
							end
						end
						tct_pkg::TCT_MODE_SQUARE: begin
							if (cnt[c] == 16'h0001) begin
								cnt[c]  <= reload[c];
								tout[c] <= 1'b1;
							end else begin
								cnt[c]  <= dec_cnt(cnt[c], ctrl[c].bcd);
								// bcd values compare as numbers since digits are ordered
								tout[c] <= (dec_cnt(cnt[c], ctrl[c].bcd) > half_cnt(reload[c], ctrl[c].bcd)); // RULE11
							end
						end
						tct_pkg::TCT_MODE_SWSTB, tct_pkg::TCT_MODE_HWSTB: begin
							if (cnt[c] == 16'h0000 && !tout[c]) begin
								tout[c] <= 1'b1;
								run[c]  <= 1'b0;
							end else begin
								cnt[c]  <= dec_cnt(cnt[c], ctrl[c].bcd);
								tout[c] <= (cnt[c] != 16'h0001); // RULE12 RULE13
							end
						end
						default: run[c] <= 1'b0;
					endcase
				end
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// outputs and interrupts
	assign stat_set = tout[`TCT_NCH-1:1] & ~gp_prev;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gp_prev    <= '1;
			irq_stat   <= `TCT_IRQ_RST;
			irq_o      <= 1'b0;
			gp_out_o   <= '1;
			baud_clk_o <= 1'b1;
		end else begin
			gp_prev <= tout[`TCT_NCH-1:1];
			// a new edge in the clearing read cycle is kept
			irq_stat   <= (stat_rd ? `TCT_IRQ_RST : irq_stat) | stat_set; // RULE15
			irq_o      <= |(((stat_rd ? `TCT_IRQ_RST : irq_stat) | stat_set) & irq_mask); // RULE3
			gp_out_o   <= tout[`TCT_NCH-1:1]; // RULE15
			// 1.23 mhz / 16x oversampling / 19200 needs a divisor of 4
			baud_clk_o <= tout[0]; // RULE2 RULE16
		end
	end

endmodule : tct_timer

// ---- hw/tct_cfg.svh ----
// constants of the three channel interval timer: register offsets, field widths, reset values, timing
// assumes byte addresses on a 32-bit avalon-mm slave port
`ifndef TCT_CFG_SVH
`define TCT_CFG_SVH

`define TCT_ADDR_W       8
`define TCT_OFF_CTRL0    8'h00
`define TCT_OFF_CTRL1    8'h04
`define TCT_OFF_CTRL2    8'h08
`define TCT_OFF_RELOAD0  8'h0c
`define TCT_OFF_RELOAD1  8'h10
`define TCT_OFF_RELOAD2  8'h14
`define TCT_OFF_COUNT0   8'h18
`define TCT_OFF_COUNT1   8'h1c
`define TCT_OFF_COUNT2   8'h20
`define TCT_OFF_STATUS   8'h24
`define TCT_OFF_MASK     8'h28
`define TCT_OFF_CMD      8'h2c
`define TCT_OFF_OUTS     8'h30

`define TCT_NCH          3
`define TCT_NGP          2
`define TCT_CW           16
`define TCT_CTRL_W       5
`define TCT_CTRL_RST     5'h00
`define TCT_RELOAD_RST   16'h0000
`define TCT_COUNT_RST    16'h0000
`define TCT_IRQ_RST      2'h0

`define TCT_SYS_KHZ      100000
`define TCT_IN_KHZ       1230
`define TCT_ACC_W        17
`define TCT_MAX_BAUD     19200

`endif

// ---- hw/tct_pkg.sv ----
// types of the three channel interval timer
// assumes tct_cfg.svh is included by the design file that uses these types
package tct_pkg;

	typedef enum logic [2:0] {
		TCT_MODE_TC     = 3'b000,
		TCT_MODE_ONESHT = 3'b001,
		TCT_MODE_RATE   = 3'b010,
		TCT_MODE_SQUARE = 3'b011,
		TCT_MODE_SWSTB  = 3'b100,
		TCT_MODE_HWSTB  = 3'b101,
		TCT_MODE_EVENT  = 3'b110
	} tct_mode_t;

	typedef struct packed {
		logic      en;
		logic      bcd;
		tct_mode_t mode;
	} tct_ctrl_t;

endpackage : tct_pkg

// ---- sim/tct_host.sv ----
// avalon-mm master model of the host processor on the local i/o bus
// assumes a slave that holds waitrequest high until it answers
`timescale 1ns/1ps

module tct_host (
	input  wire logic        clk_i,
	input  wire logic        wait_i,
	input  wire logic [31:0] rdata_i,
	output logic             rd_o,
	output logic             wr_o,
	output logic [7:0]       addr_o,
	output logic [31:0]      wdata_o,
	output logic [3:0]       be_o
);
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 32'h0;
		be_o = 4'h0;
	end

	// one access; request is held until waitrequest is sampled low
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q, output bit ok);
		int n;
		n = 0;
		@(posedge clk_i);
		rd_o <= !w;
		wr_o <= w;
		addr_o <= a;
		wdata_o <= d;
		be_o <= be;
		do begin
			@(posedge clk_i);
			n++;
		end while (wait_i !== 1'b0 && n < 64);
		ok = (wait_i === 1'b0);
		q = rdata_i;
		rd_o <= 1'b0;
		wr_o <= 1'b0;
		// released data shows no stale value
		wdata_o <= ~d;
	endtask : xfer
endmodule : tct_host

// ---- sim/tct_timer_properties.sv ----
// checker of bus handshake, interrupt and rate pulse timing of the timer
// assumes it is bound to tct_timer and sees only its ports
`timescale 1ns/1ps
`include "tct_cfg.svh"

module tct_timer_properties (
	input wire logic                   mclk_i,
	input wire logic                   rst_n_i,
	input wire logic [`TCT_ADDR_W-1:0] avs_address_i,
	input wire logic                   avs_read_i,
	input wire logic                   avs_write_i,
	input wire logic [31:0]            avs_writedata_i,
	input wire logic [3:0]             avs_byteenable_i,
	input wire logic [31:0]            avs_readdata_o,
	input wire logic                   avs_waitrequest_o,
	input wire logic [`TCT_NCH-1:0]    gate_i,
	input wire logic [`TCT_NGP-1:0]    ext_evt_i,
	input wire logic [`TCT_NGP-1:0]    evt_jmp_i,
	input wire logic                   baud_clk_o,
	input wire logic [`TCT_NGP-1:0]    gp_out_o,
	input wire logic                   irq_o
);
	logic       done;
	logic       cl;
	logic       mw;
	logic [1:0] msk;
	logic [1:0] clh;
	logic [1:0] gq;
	logic [3:0] rh;
	logic [3:0] mwh;
	logic [3:0] c1;
	logic       seen1;
	logic [7:0] lowc;
	assign done = !avs_waitrequest_o && (avs_read_i || avs_write_i);
	assign mw = done && avs_write_i && avs_address_i == `TCT_OFF_MASK;
	assign cl = mw || (done && avs_read_i && avs_address_i == `TCT_OFF_STATUS);
	////////////////////////////////////////////////////////////////////////
	// shadow of mask and timer 1 control, taken from completed writes
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			msk <= 2'h0;
			c1 <= 4'h0;
		end else if (done && avs_write_i) begin
			if (mw)
				msk <= avs_writedata_i[1:0] & {2{avs_byteenable_i[0]}};
			if (avs_address_i == `TCT_OFF_CTRL1)
				c1 <= {avs_writedata_i[4], avs_writedata_i[2:0]};
		end
	end
	// event history; a pulse cut short by a control write is not judged
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clh <= 2'h0;
			gq <= 2'h3;
			rh <= 4'h0;
			mwh <= 4'h0;
			seen1 <= 1'b0;
			lowc <= 8'h00;
		end else begin
			clh <= {clh[0], cl};
			gq <= gp_out_o;
			rh <= {rh[2:0], |(gp_out_o & ~gq)};
			mwh <= {mwh[2:0], mw};
			if (done && avs_write_i && avs_address_i == `TCT_OFF_CTRL1)
				seen1 <= 1'b0;
			else if (gq[0] && !gp_out_o[0])
				seen1 <= 1'b1;
			lowc <= gp_out_o[0] ? 8'h00 : (lowc == 8'hff ? lowc : lowc + 8'h01);
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	property p_wait_ans;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("no answer one cycle after request");
	property p_wait_one;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low over one cycle");
	property p_wait_idle;
		avs_waitrequest_o && !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
	property p_hole;
		done && avs_read_i && avs_address_i > `TCT_OFF_OUTS |-> avs_readdata_o == 32'h0;
	endproperty
	a_hole: assert property (p_hole) else $error("unmapped read not zero");
	property p_count16;
		done && avs_read_i && avs_address_i inside {`TCT_OFF_COUNT0, `TCT_OFF_COUNT1, `TCT_OFF_COUNT2}
			|-> avs_readdata_o[31:16] == 16'h0000;
	endproperty
	a_count16: assert property (p_count16) else $error("count wider than 16 bits");
	property p_irq_fall;
		$fell(irq_o) |-> |clh;
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without clear");
	property p_irq_mask;
		msk == 2'h0 && $past(msk) == 2'h0 |-> !irq_o;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while all masked");
	property p_irq_rise;
		$rose(irq_o) |-> (|(gp_out_o & ~gq)) || (|rh) || (|mwh);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without timer edge");
	property p_rate_low;
		c1 == {1'b1, tct_pkg::TCT_MODE_RATE} && seen1 && $rose(gp_out_o[0]) |-> lowc inside {[79:84]};
	endproperty
	a_rate_low: assert property (p_rate_low) else $error("rate pulse not one tick");
	c_irq: cover property ($rose(irq_o));
	c_clear: cover property ($fell(irq_o));
	c_hole: cover property (done && avs_read_i && avs_address_i > `TCT_OFF_OUTS);
endmodule : tct_timer_properties

bind tct_timer tct_timer_properties u_prop (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .gate_i(gate_i),
	.ext_evt_i(ext_evt_i), .evt_jmp_i(evt_jmp_i), .baud_clk_o(baud_clk_o), .gp_out_o(gp_out_o),
	.irq_o(irq_o)
);

// ---- sim/test_tct_timer.sv ----
// self-checking bench of the interval timer: reads are scored from a queue
// assumes tct_host as bus master and the checker bound to the design
`timescale 1ns/1ps
`include "tct_cfg.svh"

module test_tct_timer;
	typedef struct packed {
		logic [31:0] e;
		logic [31:0] m;
	} tct_exp_t;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        rd, wr, wt;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [3:0]  be;
	logic [2:0]  gate_i = 3'h0;
	logic [1:0]  ext_evt_i = 2'h0;
	logic [1:0]  evt_jmp_i = 2'h0;
	logic        baud, irq;
	logic [1:0]  gp;
	logic [2:0]  outs;
	tct_exp_t    q[$];
	tct_exp_t    x;
	int          fails = 0;
	int          tests_run = 0;
	assign outs = {gp, baud};
	always #5 mclk_i = ~mclk_i;

	tct_timer dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wt), .gate_i(gate_i), .ext_evt_i(ext_evt_i), .evt_jmp_i(evt_jmp_i),
		.baud_clk_o(baud), .gp_out_o(gp), .irq_o(irq));
	tct_host host (.clk_i(mclk_i), .wait_i(wt), .rdata_i(rdata), .rd_o(rd), .wr_o(wr), .addr_o(addr),
		.wdata_o(wdata), .be_o(be));
	////////////////////////////////////////////////////////////////////////
	task test_done;
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b,
		input logic [31:0] m);
		logic [31:0] r;
		bit ok;
		if (!w)
			q.push_back('{d, m});
		host.xfer(w, a, d, b, r, ok);
		if (!ok) begin
			fails++;
			$display("BAD %0t bus timeout", $time);
			test_done();
		end
	endtask : acc
	task wrr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 4'hf, 32'h0);
	endtask : wrr
	task rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		acc(1'b0, a, e, 4'hf, m);
	endtask : rdc
	// waits while output b holds lvl, bounded, and checks the length
	task span(input int b, input logic lvl, input int lo, input int hi);
		int n;
		n = 0;
		while (outs[b] === lvl && n <= hi) begin
			@(posedge mclk_i);
			n++;
		end
		tests_run++;
		if (n < lo || n > hi) begin
			fails++;
			$display("BAD %0t out %0d held %0d cycles", $time, b, n);
		end
	endtask : span
	task chk(input logic c);
		tests_run++;
		if (c !== 1'b1) begin
			fails++;
			$display("BAD %0t level check", $time);
		end
	endtask : chk
	task pulse(input int b);
		gate_i[b] <= 1'b1;
		repeat (4) @(posedge mclk_i);
		gate_i[b] <= 1'b0;
	endtask : pulse
	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk_i) begin
		if (rd && wt === 1'b0) begin
			x = q.size() ? q.pop_front() : '{32'h0, ALL};
			tests_run++;
			if ((rdata & x.m) !== (x.e & x.m)) begin
				fails++;
				$display("BAD %0t read %h expected %h", $time, rdata, x.e);
			end
		end
	end
	initial begin
		int k;
		logic [31:0] v;
		void'($urandom(61634));
		repeat (12) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		for (int a = 0; a <= 'h34; a += 4)
			rdc(a[7:0], (a == 'h30) ? 32'h7 : 32'h0, ALL);
		rdc(8'hfc, 32'h0, ALL);
		for (int m = 0; m < 7; m++) begin
			v = {27'h0, 1'b0, 1'($urandom_range(1, 0)), m[2:0]};
			wrr(`TCT_OFF_CTRL2, v);
			rdc(`TCT_OFF_CTRL2, v, ALL);
		end
		wrr(`TCT_OFF_MASK, 32'h3);
		acc(1'b1, `TCT_OFF_MASK, 32'h3, 4'h0, 32'h0);
		rdc(`TCT_OFF_MASK, 32'h0, ALL);
		// terminal count on timer 0, then live reads across the wrap
		for (int d = 0; d < 2; d++) begin
			wrr(`TCT_OFF_CTRL0, {27'h0, 1'b1, d[0], 3'h0});
			wrr(`TCT_OFF_RELOAD0, 32'h2);
			span(0, 1'b1, 0, 8);
			span(0, 1'b0, 80, 175);
			repeat (118) @(posedge mclk_i);
			rdc(`TCT_OFF_COUNT0, d ? 32'h9999 : 32'hffff, ALL);
			repeat (160) @(posedge mclk_i);
			rdc(`TCT_OFF_COUNT0, d ? 32'h9997 : 32'hfffd, ALL);
		end
		// rate generator on timer 1 feeding the interrupt, then square wave on timer 1
		wrr(`TCT_OFF_MASK, 32'h1);
		wrr(`TCT_OFF_CTRL1, 32'h12);
		wrr(`TCT_OFF_RELOAD1, 32'h4);
		span(1, 1'b1, 0, 400);
		span(1, 1'b0, 79, 84);
		span(1, 1'b1, 240, 247);
		chk(irq);
		rdc(`TCT_OFF_STATUS, 32'h1, 32'h1);
		repeat (3) @(posedge mclk_i);
		chk(!irq);
		wrr(`TCT_OFF_CTRL1, 32'h13);
		wrr(`TCT_OFF_RELOAD1, 32'h4);
		span(1, 1'b1, 0, 400);
		span(1, 1'b0, 160, 166);
		span(1, 1'b1, 160, 166);
		// hardware strobe, timer 1
		wrr(`TCT_OFF_CTRL1, 32'h15);
		wrr(`TCT_OFF_RELOAD1, 32'h2);
		pulse(1);
		span(1, 1'b1, 76, 260);
		span(1, 1'b0, 79, 84);
		// one-shot on timer 2: software start, pin retrigger mid-pulse
		wrr(`TCT_OFF_MASK, 32'h2);
		wrr(`TCT_OFF_CTRL2, 32'h11);
		wrr(`TCT_OFF_RELOAD2, 32'h3);
		wrr(`TCT_OFF_CMD, 32'h4);
		span(2, 1'b1, 0, 8);
		repeat (150) @(posedge mclk_i);
		pulse(2);
		span(2, 1'b0, 150, 255);
		rdc(`TCT_OFF_STATUS, 32'h2, 32'h2);
		// software strobe, timer 2
		wrr(`TCT_OFF_CTRL2, 32'h14);
		repeat (300) @(posedge mclk_i);
		chk(gp[1]);
		wrr(`TCT_OFF_RELOAD2, 32'h2);
		span(2, 1'b1, 76, 260);
		span(2, 1'b0, 79, 84);
		// external events on timer 2
		evt_jmp_i <= 2'b10;
		wrr(`TCT_OFF_CTRL2, 32'h16);
		wrr(`TCT_OFF_RELOAD2, 32'ha);
		k = $urandom_range(8, 1);
		repeat (k) begin
			ext_evt_i[1] <= 1'b1;
			repeat (3) @(posedge mclk_i);
			ext_evt_i[1] <= 1'b0;
			repeat (5) @(posedge mclk_i);
		end
		rdc(`TCT_OFF_COUNT2, 32'(10 - k), ALL);
		// timer 0 as baud source: divide by 64 checks time base accuracy
		wrr(`TCT_OFF_CTRL0, 32'h12);
		wrr(`TCT_OFF_RELOAD0, 32'h40);
		span(0, 1'b1, 0, 5400);
		span(0, 1'b0, 79, 84);
		span(0, 1'b1, 5118, 5127);
		span(0, 1'b0, 79, 84);
		// divisor 4 is the top rate with 16x oversampling; reload while high
		wrr(`TCT_OFF_RELOAD0, 32'h4);
		span(0, 1'b1, 0, 400);
		span(0, 1'b0, 79, 84);
		span(0, 1'b1, 240, 247);
		test_done();
	end
endmodule : test_tct_timer
